// ==== ddr_link_pkg.sv ====
// Purpose: shared constants, command codes and strobe framing for the DDR link
// Assumes: link clock is ref_clk divided by CK_DIV; all link counts are in link cycles
// Notes: nanosecond minimums are held in ps and rounded up to whole link cycles
package ddr_link_pkg;
  localparam int REF_PS   = 20000;          // ref_clk period, 50 MHz
  localparam int CK_DIV   = 4;              // ref cycles per link cycle, power of two, at least 4
  localparam int CK_HALF  = CK_DIV / 2;
  localparam int CK_PS    = REF_PS * CK_DIV;
  localparam int DIV_W    = 2;              // log2 of CK_DIV
  localparam int BANK_W   = 2;
  localparam int NBANK    = 1 << BANK_W;
  localparam int COL_W    = 4;
  localparam int DQ_W     = 16;             // two beats packed per link cycle
  localparam int BL       = 8;
  localparam int BL2      = BL / 2;         // link cycles per burst
  localparam int BEAT_W   = 2;
  localparam int POS_W    = 4;
  localparam int CNT_W    = 5;
  localparam int MEM_W    = BANK_W + COL_W + BEAT_W;

  localparam logic [POS_W-1:0] RL       = 4'h5;  // read latency, plain default
  localparam logic [POS_W-1:0] WL       = 4'h5;  // write latency, plain default
  localparam logic [POS_W-1:0] BURST_CK = 4'h4;  // equals BL2

  // minimum spacings: time in ps and floor in link cycles
  localparam int RTP_PS  = 7500;
  localparam int RTP_MIN = 4;
  localparam int WTR_PS  = 7500;
  localparam int WTR_MIN = 4;
  localparam int MRD_MIN = 4;
  localparam int MOD_PS  = 15000;
  localparam int MOD_MIN = 12;
  localparam int RCD_PS  = 13750;           // speed grade, set per bin
  localparam int RC_PS   = 48750;           // speed grade, set per bin

  // round a ps minimum up to link cycles, never below the cycle floor
  function automatic int to_ck(input int ps, input int floor);
    int c;
    c = (ps + CK_PS - 1) / CK_PS;
    return (c > floor) ? c : floor;
  endfunction

  localparam logic [CNT_W-1:0] RTP_CK   = CNT_W'(to_ck(RTP_PS, RTP_MIN));
  localparam logic [CNT_W-1:0] WR_RD_CK = CNT_W'(int'(WL) + BL2 + to_ck(WTR_PS, WTR_MIN));
  localparam logic [CNT_W-1:0] MRD_CK   = CNT_W'(MRD_MIN);
  localparam logic [CNT_W-1:0] MOD_CK   = CNT_W'(to_ck(MOD_PS, MOD_MIN));
  localparam logic [CNT_W-1:0] RCD_CK   = CNT_W'(to_ck(RCD_PS, 1));
  localparam logic [CNT_W-1:0] RC_CK    = CNT_W'(to_ck(RC_PS, 1));

  typedef enum logic [2:0] {CmdNop, CmdAct, CmdRd, CmdWr, CmdPre, CmdMrs} cmd_e;

  // strobe frame for burst cycle idx: {drive, true level}; preamble one cycle early
  function automatic logic [1:0] strobe_at(input logic [POS_W-1:0] idx, input logic [POS_W-1:0] first);
    logic [POS_W-1:0] off;
    off = idx - first;
    strobe_at[1] = (idx >= first - 4'h1) && (idx < first + BURST_CK);
    strobe_at[0] = (idx >= first) && !off[0];
  endfunction

  // data beats occupy BURST_CK cycles from first
  function automatic logic in_data(input logic [POS_W-1:0] idx, input logic [POS_W-1:0] first);
    in_data = (idx >= first) && (idx < first + BURST_CK);
  endfunction
endpackage

// ==== ddr_link_if.sv ====
// Purpose: command, data and strobe wires between controller end and device end
// Assumes: ck is made by the controller end
// Notes: wire levels are resolved here from the enables; nobody driving reads low
interface ddr_link_if;
  import ddr_link_pkg::*;
  logic              ck;        // link clock from the controller
  cmd_e              cmd;       // command, sampled on rising ck
  logic [BANK_W-1:0] bank;      // bank select
  logic [COL_W-1:0]  addr;      // column or mode value
  logic [DQ_W-1:0]   dqCtlO;    // write data out
  logic              dqCtlOe;   // controller drives dq
  logic [DQ_W-1:0]   dqDevO;    // read data out
  logic              dqDevOe;   // device drives dq
  logic [1:0]        dqsCtlO;   // write strobe {true, complement}
  logic              dqsCtlOe;  // controller drives dqs
  logic [1:0]        dqsDevO;   // read strobe {true, complement}
  logic              dqsDevOe;  // device drives dqs
  logic [DQ_W-1:0]   dq;        // resolved data wire
  logic [1:0]        dqs;       // resolved strobe pair

  // a clash of both enables is a protocol fault; the device is shown then
  assign dq  = dqDevOe ? dqDevO : (dqCtlOe ? dqCtlO : '0);
  assign dqs = dqsDevOe ? dqsDevO : (dqsCtlOe ? dqsCtlO : 2'h0);

  modport ctl (output ck, cmd, bank, addr, dqCtlO, dqCtlOe, dqsCtlO, dqsCtlOe, input dq);
  modport dev (input ck, cmd, bank, addr, dq, output dqDevO, dqDevOe, dqsDevO, dqsDevOe);
endinterface

// ==== ddr_dev_end.sv ====
// Purpose: device end, stores bursts and answers reads with framed strobes
// Assumes: controller keeps all command spacing; link inputs are source-synchronous to ck
// Notes: whole logic runs on the link clock; memory is small and flat
module ddr_dev_end (
  input  wire logic                      rst_n,     // async reset, active low
  ddr_link_if.dev                        link,      // link to the controller
  output logic [ddr_link_pkg::NBANK-1:0] bankOpen,  // banks currently activated
  output logic [ddr_link_pkg::COL_W-1:0] modeVal    // last mode register value
);
  import ddr_link_pkg::*;

  logic [DQ_W-1:0]   mem [1 << MEM_W];
  logic [POS_W-1:0]  rdPos_q;   // burst index plus one, zero when idle
  logic [POS_W-1:0]  rdPos_d;
  logic [POS_W-1:0]  wrPos_q;
  logic [POS_W-1:0]  wrPos_d;
  logic [POS_W-1:0]  rdIdx;
  logic [POS_W-1:0]  wrIdx;
  logic [POS_W-1:0]  rdOff;
  logic [POS_W-1:0]  wrOff;
  logic [BANK_W-1:0] rdBank_q;
  logic [COL_W-1:0]  rdCol_q;
  logic [BANK_W-1:0] wrBank_q;
  logic [COL_W-1:0]  wrCol_q;
  logic [1:0]        rdFrame;

  // next burst positions; a read ends once the release cycle is reached
  always_comb begin
    rdPos_d = 4'h0;
    wrPos_d = 4'h0;
    if (link.cmd == CmdRd) begin
      rdPos_d = 4'h1;
    end else if (rdPos_q != 4'h0 && rdPos_q <= RL + BURST_CK) begin
      rdPos_d = rdPos_q + 4'h1;
    end
    if (link.cmd == CmdWr) begin
      wrPos_d = 4'h1;
    end else if (wrPos_q != 4'h0 && wrPos_q < WL + BURST_CK) begin
      wrPos_d = wrPos_q + 4'h1;
    end
    rdIdx   = rdPos_d - 4'h1;
    wrIdx   = wrPos_d - 4'h1;
    rdOff   = rdIdx - RL;
    wrOff   = wrIdx - WL;
    rdFrame = (rdPos_d != 4'h0) ? strobe_at(rdIdx, RL) : 2'h0;
  end

  // burst tracking and captured addresses
  always_ff @(posedge link.ck or negedge rst_n) begin
    if (!rst_n) begin
      rdPos_q  <= 4'h0;
      wrPos_q  <= 4'h0;
      rdBank_q <= '0;
      rdCol_q  <= '0;
      wrBank_q <= '0;
      wrCol_q  <= '0;
    end else begin
      rdPos_q <= rdPos_d;
      wrPos_q <= wrPos_d;
      if (link.cmd == CmdRd) begin
        rdBank_q <= link.bank;
        rdCol_q  <= link.addr;
      end
      if (link.cmd == CmdWr) begin
        wrBank_q <= link.bank;
        wrCol_q  <= link.addr;
      end
    end
  end

  // bank state and mode value, only for observation
  always_ff @(posedge link.ck or negedge rst_n) begin
    if (!rst_n) begin
      bankOpen <= '0;
      modeVal  <= '0;
    end else begin
      case (link.cmd)
        CmdAct:  bankOpen[link.bank] <= 1'b1;
        CmdPre:  bankOpen[link.bank] <= 1'b0;
        CmdMrs:  modeVal <= link.addr;
        default: ;
      endcase
    end
  end

  // write beats land at fixed latency; strobe is not checked here
  always_ff @(posedge link.ck) begin
    if (wrPos_d != 4'h0 && in_data(wrIdx, WL)) begin
      mem[{wrBank_q, wrCol_q, wrOff[BEAT_W-1:0]}] <= link.dq;
    end
  end

  // read strobe: drive from RL-1 with low preamble, release at RL+BL/2
  always_ff @(posedge link.ck or negedge rst_n) begin
    if (!rst_n) begin
      link.dqsDevOe <= 1'b0;
      link.dqsDevO  <= 2'h0;
    end else begin
      link.dqsDevOe <= rdFrame[1];
      link.dqsDevO  <= {rdFrame[0], ~rdFrame[0]};
    end
  end

  // read data: first beat at fixed latency after the read
  always_ff @(posedge link.ck or negedge rst_n) begin
    if (!rst_n) begin
      link.dqDevOe <= 1'b0;
      link.dqDevO  <= '0;
    end else begin
      link.dqDevOe <= (rdPos_d != 4'h0) && in_data(rdIdx, RL);
      link.dqDevO  <= mem[{rdBank_q, rdCol_q, rdOff[BEAT_W-1:0]}];
    end
  end
endmodule // ddr_dev_end

// ==== ddr_ctl_end.sv ====
// Purpose: controller end, issues link commands with legal spacing and moves bursts
// Assumes: one request at a time; the device answers at fixed read latency
// Notes: link clock is ref_clk divided down; read data crosses by two flip-flops
//
// Overview of operation
// - read to precharge, same bank, spaced
// - write data end to read, spaced
// - mode set spacing and mode-to-command wait
// - write strobe low preamble before first edge
// - write strobe postamble before release
// - device read postamble after last edge
// - device drives read strobe at RL-1
// - device releases read strobe at RL+BL/2
// - activate to read or write delay
// - activate to activate minimum period
// - read data arrives at fixed latency
module ddr_ctl_end (
  input  wire logic                               ref_clk,    // system clock
  input  wire logic                               rst_n,      // async reset, active low
  ddr_link_if.ctl                                 link,       // link to the device
  input  wire logic                               reqValid,   // request offered
  output logic                                    reqReady,   // request taken this cycle
  input  wire ddr_link_pkg::cmd_e                 reqCmd,     // command to issue
  input  wire logic [ddr_link_pkg::BANK_W-1:0]    reqBank,    // bank
  input  wire logic [ddr_link_pkg::COL_W-1:0]     reqAddr,    // column or mode value
  input  wire logic [ddr_link_pkg::DQ_W*4-1:0]    reqWdata,   // write burst, beat 0 low
  output logic                                    rspValid,   // read burst done, pulse
  output logic [ddr_link_pkg::DQ_W*4-1:0]         rspRdata    // read burst, beat 0 low
);
  import ddr_link_pkg::*;

  typedef enum logic [1:0] {Idle, Issue, Burst} ctl_state_e;

  ctl_state_e        st_q;
  logic [DIV_W-1:0]  div_q;
  logic              tick;      // link ck falls at this edge
  logic              samp;      // link ck rises at this edge, mid link cycle
  logic [DQ_W-1:0]   dqS1_q;
  logic [DQ_W-1:0]   dqS2_q;
  cmd_e              pCmd_q;
  logic [BANK_W-1:0] pBank_q;
  logic [COL_W-1:0]  pAddr_q;
  logic [DQ_W*4-1:0] wdat_q;
  logic [POS_W-1:0]  pos_q;     // burst cycle index of the cycle on the link
  logic [POS_W-1:0]  posNx;
  logic [POS_W-1:0]  wOff;
  logic [POS_W-1:0]  rOff;
  logic [1:0]        wFrame;
  logic              legal;
  logic [CNT_W-1:0]  rtpCnt_q [NBANK];
  logic [CNT_W-1:0]  rcdCnt_q [NBANK];
  logic [CNT_W-1:0]  rcCnt_q  [NBANK];
  logic [CNT_W-1:0]  wtrCnt_q;
  logic [CNT_W-1:0]  mrdCnt_q;
  logic [CNT_W-1:0]  modCnt_q;

  assign tick = (div_q == DIV_W'(CK_DIV - 1));
  assign samp = (div_q == DIV_W'(CK_HALF - 1));

  // link clock divider; ck rises mid-count so link outputs settle half a cycle early
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q   <= '0;
      link.ck <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      if (samp) begin
        link.ck <= 1'b1;
      end else if (tick) begin
        link.ck <= 1'b0;
      end
    end
  end

  // read data crosses from the link domain; only the second stage is used
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqS1_q <= '0;
      dqS2_q <= '0;
    end else begin
      dqS1_q <= link.dq;
      dqS2_q <= dqS1_q;
    end
  end

  // spacing check against the counters; a zero counter means the gap is met
  always_comb begin
    legal = 1'b0;
    case (reqCmd)
      CmdRd: begin
        legal = (rcdCnt_q[reqBank] == '0)
              && (wtrCnt_q == '0)
              && (modCnt_q == '0);
      end
      CmdWr: begin
        legal = (rcdCnt_q[reqBank] == '0)
              && (modCnt_q == '0);
      end
      CmdPre: begin
        legal = (rtpCnt_q[reqBank] == '0)
              && (modCnt_q == '0);
      end
      CmdAct: begin
        legal = (rcCnt_q[reqBank] == '0)
              && (modCnt_q == '0);
      end
      CmdMrs: begin
        legal = (mrdCnt_q == '0);
      end
      default: legal = 1'b1;
    endcase
  end

  assign reqReady = (st_q == Idle) && legal;

  // request capture and burst sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= Idle;
      pCmd_q  <= CmdNop;
      pBank_q <= '0;
      pAddr_q <= '0;
      wdat_q  <= '0;
      pos_q   <= 4'h0;
    end else begin
      case (st_q)
        Idle: begin
          if (reqValid && reqReady) begin
            st_q    <= Issue;
            pCmd_q  <= reqCmd;
            pBank_q <= reqBank;
            pAddr_q <= reqAddr;
            wdat_q  <= reqWdata;
          end
        end
        Issue: begin
          if (tick) begin
            pos_q <= 4'h0;
            st_q  <= (pCmd_q == CmdRd || pCmd_q == CmdWr) ? Burst : Idle;
          end
        end
        Burst: begin
          if (tick) begin
            pos_q <= posNx;
            if (pCmd_q == CmdWr && posNx == WL + BURST_CK) begin
              st_q <= Idle;  // strobe released in this cycle
            end
          end else if (samp && pCmd_q == CmdRd && pos_q == RL + BURST_CK) begin
            st_q <= Idle;
          end
        end
        default: st_q <= Idle;
      endcase
    end
  end

  // per-bank and global gap counters, loaded on issue, counted in link cycles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < NBANK; b++) begin
        rtpCnt_q[b] <= '0;
        rcdCnt_q[b] <= '0;
        rcCnt_q[b]  <= '0;
      end
      wtrCnt_q <= '0;
      mrdCnt_q <= '0;
      modCnt_q <= '0;
    end else if (tick) begin
      for (int b = 0; b < NBANK; b++) begin
        if (rtpCnt_q[b] != '0) rtpCnt_q[b] <= rtpCnt_q[b] - 1'b1;
        if (rcdCnt_q[b] != '0) rcdCnt_q[b] <= rcdCnt_q[b] - 1'b1;
        if (rcCnt_q[b] != '0)  rcCnt_q[b]  <= rcCnt_q[b] - 1'b1;
      end
      if (wtrCnt_q != '0) wtrCnt_q <= wtrCnt_q - 1'b1;
      if (mrdCnt_q != '0) mrdCnt_q <= mrdCnt_q - 1'b1;
      if (modCnt_q != '0) modCnt_q <= modCnt_q - 1'b1;
      if (st_q == Issue) begin
        case (pCmd_q)
          CmdRd:  rtpCnt_q[pBank_q] <= RTP_CK;
          CmdWr:  wtrCnt_q <= WR_RD_CK;
          CmdAct: begin
            rcdCnt_q[pBank_q] <= RCD_CK;
            rcCnt_q[pBank_q]  <= RC_CK;
          end
          CmdMrs: begin
            mrdCnt_q <= MRD_CK;
            modCnt_q <= MOD_CK;
          end
          default: ;
        endcase
      end
    end
  end

  // command pins change on the falling ck so the device sees them settled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.cmd  <= CmdNop;
      link.bank <= '0;
      link.addr <= '0;
    end else if (tick) begin
      link.cmd <= (st_q == Issue) ? pCmd_q : CmdNop;
      if (st_q == Issue) begin
        link.bank <= pBank_q;
        link.addr <= pAddr_q;
      end
    end
  end

  // write burst framing for the next link cycle
  always_comb begin
    posNx  = (st_q == Issue) ? 4'h0 : pos_q + 4'h1;
    wOff   = posNx - WL;
    rOff   = pos_q - RL - 4'h1;  // sync stages hold the beat seen at the last tick, one burst cycle behind pos_q
    wFrame = (pCmd_q == CmdWr && st_q != Idle) ? strobe_at(posNx, WL) : 2'h0;
  end

  // strobe low for the preamble cycle, low through the last cycle as postamble
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.dqsCtlOe <= 1'b0;
      link.dqsCtlO  <= 2'h0;
      link.dqCtlOe  <= 1'b0;
      link.dqCtlO   <= '0;
    end else if (tick) begin
      link.dqsCtlOe <= wFrame[1];
      link.dqsCtlO  <= {wFrame[0], ~wFrame[0]};
      link.dqCtlOe  <= wFrame[1] && in_data(posNx, WL);
      link.dqCtlO   <= wdat_q[wOff[BEAT_W-1:0]*DQ_W +: DQ_W];
    end
  end

  // read beats are taken one link cycle late; two sync stages eat the rest of the cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspRdata <= '0;
      rspValid <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      if (samp && st_q == Burst && pCmd_q == CmdRd && in_data(pos_q - 4'h1, RL)) begin
        rspRdata[rOff[BEAT_W-1:0]*DQ_W +: DQ_W] <= dqS2_q;
        rspValid <= (pos_q == RL + BURST_CK);
      end
    end
  end
endmodule // ddr_ctl_end

// ==== ddr_link_props.sv ====
// Purpose: protocol checks on the link between controller end and device end
// Assumes: sampled on falling ck, where both ends' outputs have settled
// Notes: latencies follow RL = WL = 5 and a four-cycle burst
module ddr_link_props (
  input wire logic               rst_n,     // async reset, active low
  input wire logic               ck,        // link clock
  input wire ddr_link_pkg::cmd_e cmd,       // link command
  input wire logic               dqCtlOe,   // controller drives dq
  input wire logic               dqsCtlOe,  // controller drives dqs
  input wire logic [1:0]         dqsCtlO,   // write strobe
  input wire logic               dqDevOe,   // device drives dq
  input wire logic               dqsDevOe,  // device drives dqs
  input wire logic [1:0]         dqsDevO    // read strobe
);
  import ddr_link_pkg::*;

  // falling ck sees the cycle's command and the device's registered answer together
  default clocking cb @(negedge ck);
  endclocking
  default disable iff (!rst_n);

  property p_rd_lead;
    cmd == CmdRd |-> ##3 !dqsDevOe ##1 (dqsDevOe && dqsDevO == 2'h1);
  endproperty
  a_rd_lead: assert property (p_rd_lead) else $error("read strobe preamble misplaced");

  property p_rd_data;
    cmd == CmdRd |-> ##5 (dqDevOe && dqsDevO == 2'h2) ##1 (dqDevOe && dqsDevO == 2'h1)
      ##1 (dqDevOe && dqsDevO == 2'h2);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not at fixed latency");

  property p_rd_post;
    cmd == CmdRd |-> ##8 (dqsDevOe && dqDevOe && dqsDevO == 2'h1);
  endproperty
  a_rd_post: assert property (p_rd_post) else $error("read postamble missing");

  property p_rd_rel;
    cmd == CmdRd |-> ##9 (!dqsDevOe && !dqDevOe);
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("read strobe not released");

  property p_wr_pre;
    cmd == CmdWr |-> ##4 (dqsCtlOe && !dqCtlOe && dqsCtlO == 2'h1) ##1 (dqCtlOe && dqsCtlO == 2'h2);
  endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("write preamble missing");

  property p_wr_post;
    cmd == CmdWr |-> ##8 (dqsCtlOe && dqsCtlO == 2'h1) ##1 (!dqsCtlOe && !dqCtlOe);
  endproperty
  a_wr_post: assert property (p_wr_post) else $error("write postamble missing");

  // stricter than same-bank: the controller is busy for any precharge then
  property p_rtp;
    cmd == CmdRd |-> ##1 (cmd != CmdPre) [*3];
  endproperty
  a_rtp: assert property (p_rtp) else $error("precharge too soon after read");

  property p_wtr;
    cmd == CmdWr |-> ##1 (cmd != CmdRd) [*8] ##1 (cmd != CmdRd) [*4];
  endproperty
  a_wtr: assert property (p_wtr) else $error("read too soon after write");

  property p_mrd;
    cmd == CmdMrs |-> ##1 (cmd != CmdMrs) [*3];
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode sets too close");

  property p_mod;
    cmd == CmdMrs |-> ##1 (cmd inside {CmdNop, CmdMrs}) [*8] ##1 (cmd inside {CmdNop, CmdMrs}) [*3];
  endproperty
  a_mod: assert property (p_mod) else $error("command too soon after mode set");

  // main traffic seen
  c_rd: cover property (cmd == CmdRd ##9 !dqsDevOe);
  c_wr: cover property (cmd == CmdWr ##9 !dqsCtlOe);
  c_mrs: cover property (cmd == CmdMrs);
endmodule // ddr_link_props

// ==== test_sdram_command_spacing_rules.sv ====
// Purpose: drives the controller end against the device end and judges results
// Assumes: link clock comes from the controller end
// Notes: command gaps are timestamped in link cycles on falling ck
module test_sdram_command_spacing_rules;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_link_pkg::*;

  logic                ref_clk;
  logic                rst_n;
  logic                reqValid;
  logic                reqReady;
  cmd_e                reqCmd;
  logic [BANK_W-1:0]   reqBank;
  logic [COL_W-1:0]    reqAddr;
  logic [DQ_W*4-1:0]   reqWdata;
  logic                rspValid;
  logic [DQ_W*4-1:0]   rspRdata;
  logic [NBANK-1:0]    bankOpen;
  logic [COL_W-1:0]    modeVal;
  int                  fail_count;
  int                  compares;
  int                  linkCyc;
  int                  at [8];

  ddr_link_if ddr_link_if_inst ();

  ddr_ctl_end ddr_ctl_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(ddr_link_if_inst),
    .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata));

  ddr_dev_end ddr_dev_end_inst (.rst_n(rst_n), .link(ddr_link_if_inst), .bankOpen(bankOpen),
    .modeVal(modeVal));

  ddr_link_props ddr_link_props_inst (.rst_n(rst_n), .ck(ddr_link_if_inst.ck), .cmd(ddr_link_if_inst.cmd),
    .dqCtlOe(ddr_link_if_inst.dqCtlOe), .dqsCtlOe(ddr_link_if_inst.dqsCtlOe),
    .dqsCtlO(ddr_link_if_inst.dqsCtlO), .dqDevOe(ddr_link_if_inst.dqDevOe),
    .dqsDevOe(ddr_link_if_inst.dqsDevOe), .dqsDevO(ddr_link_if_inst.dqsDevO));

  // free-running system clock
  always #10 ref_clk = ~ref_clk;

  // last link cycle of each command kind, for gap checks
  always @(negedge ddr_link_if_inst.ck) begin
    linkCyc++;
    if (ddr_link_if_inst.cmd !== CmdNop) at[int'(ddr_link_if_inst.cmd)] = linkCyc;
  end

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_gap(input string what, input int minGap, input int gap);
    compares++;
    if (gap < minGap) begin
      fail_count++;
      $display("BAD %s expected at least %0d seen %0d", what, minGap, gap);
    end
  endtask

  // hold the request until a rising edge takes it with ready high
  task automatic req(input cmd_e c, input logic [BANK_W-1:0] b, input logic [COL_W-1:0] a,
                     input logic [DQ_W*4-1:0] d);
    int n;
    @(negedge ref_clk);
    reqValid = 1'b1;
    reqCmd = c;
    reqBank = b;
    reqAddr = a;
    reqWdata = d;
    n = 0;
    while (reqReady !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 500) begin
      fail_count++;
      $display("BAD reqReady expected 1 seen %b", reqReady);
    end
    @(negedge ref_clk);
    reqValid = 1'b0;
  endtask

  task automatic rd(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] a, output logic [63:0] d);
    int n;
    req(CmdRd, b, a, 64'h0);
    n = 0;
    while (rspValid !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    cmp("rspValid", 64'h1, 64'(rspValid));
    d = rspRdata;
  endtask

  // command reaches the device within a link cycle or two
  task automatic settle();
    repeat (12) @(negedge ref_clk);
  endtask

  task automatic t_write_read();
    logic [63:0] d;
    req(CmdAct, 2'h1, 4'h0, 64'h0);
    settle();
    cmp("bankOpen", 64'h2, 64'(bankOpen));
    req(CmdWr, 2'h1, 4'h3, 64'h0123_4567_89ab_cdef);
    rd(2'h1, 4'h3, d);
    cmp("rdata b1", 64'h0123_4567_89ab_cdef, d);
    cmp_gap("wr to rd", int'(WL) + BL2 + WTR_MIN, at[CmdRd] - at[CmdWr]);
    cmp_gap("act to wr", 1, at[CmdWr] - at[CmdAct]);
    $display("test write_read done");
  endtask

  task automatic t_banks();
    logic [63:0] d;
    req(CmdAct, 2'h2, 4'h0, 64'h0);
    req(CmdWr, 2'h2, 4'h5, 64'hfedc_ba98_7654_3210);
    rd(2'h1, 4'h3, d);
    cmp("rdata b1 kept", 64'h0123_4567_89ab_cdef, d);
    req(CmdPre, 2'h1, 4'h0, 64'h0);
    settle();
    cmp_gap("rd to pre", RTP_MIN, at[CmdPre] - at[CmdRd]);
    cmp("bankOpen", 64'h4, 64'(bankOpen));
    rd(2'h2, 4'h5, d);
    cmp("rdata b2", 64'hfedc_ba98_7654_3210, d);
    $display("test banks done");
  endtask

  task automatic t_mode();
    int first;
    req(CmdMrs, 2'h0, 4'ha, 64'h0);
    settle();
    first = at[CmdMrs];
    req(CmdMrs, 2'h0, 4'h5, 64'h0);
    req(CmdAct, 2'h0, 4'h0, 64'h0);
    settle();
    cmp_gap("mrs to mrs", MRD_MIN, at[CmdMrs] - first);
    cmp_gap("mrs to act", MOD_MIN, at[CmdAct] - at[CmdMrs]);
    cmp("modeVal", 64'h5, 64'(modeVal));
    cmp("bankOpen", 64'h5, 64'(bankOpen));
    $display("test mode done");
  endtask

  task automatic stop_test();
    $display("counts compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = CmdNop;
    reqBank = '0;
    reqAddr = '0;
    reqWdata = '0;
    fail_count = 0;
    compares = 0;
    linkCyc = 0;
    foreach (at[i]) at[i] = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_write_read();
    t_banks();
    t_mode();
    stop_test();
  end

  // scenarios need well under 2000 cycles; 20000 means a hang
  initial begin
    #400000;
    fail_count++;
    $display("BAD watchdog expected finish seen timeout");
    stop_test();
  end
endmodule // test_sdram_command_spacing_rules
